// *** hdl/usbd_top.sv ***
`default_nettype none
`include "usbd_regs.svh"

module usbd_top (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Reset cause, valid while reset is high
    input wire logic reset_power_up,
    input wire logic reset_to_value,
    input wire logic reset_pd_value,
    // Register bus
    input wire usbd_pkg::usbd_apb_req_t apb_req,
    output usbd_pkg::usbd_apb_rsp_t apb_rsp,
    // Core events
    input wire logic pc_step,
    input wire logic alu_flags_we,
    input wire logic [2:0] alu_flags,
    // Port B pins
    input wire logic [7:0] port_b_in,
    output logic [7:0] port_b_out,
    output logic [7:0] port_b_oe,
    // Core state
    output logic [12:0] pc_value,
    output usbd_pkg::usbd_status_t status_value,
    output logic [7:0] option_value,
    output logic [7:0] interrupt_control_value
);

    // Storage
    logic [7:0] pointer_reg;
    logic [7:0] timer_zero_count_reg;
    logic [4:0] pc_high_holding_reg;
    logic [12:0] pc_reg;
    logic [7:0] pc_low;
    logic [7:0] dir_q;
    logic [7:0] pins_level;

    // Bus decode
    logic [8:0] req_idx;
    logic req_in_range;
    logic setup_phase;
    logic access_phase;
    logic wr_fire;
    logic [7:0] wbyte;
    usbd_pkg::usbd_target_t target;
    logic [8:0] eff_addr;
    logic [7:0] rd_byte;

    assign req_idx = apb_req.paddr[`USBD_APB_IDX_MSB:`USBD_APB_IDX_LSB];
    assign req_in_range = ~apb_req.paddr[`USBD_APB_TOP];
    assign setup_phase = apb_req.psel & ~apb_req.penable;
    assign access_phase = apb_req.psel & apb_req.penable & apb_rsp.pready;
    assign wr_fire = access_phase & apb_req.pwrite & req_in_range;
    assign wbyte = apb_req.pwdata[7:0];

    usbd_decode u_decode (
        .addr(req_idx),
        .irp(status_value.irp),
        .pointer(pointer_reg),
        .target(target),
        .eff_addr(eff_addr)
    );

    usbd_port_b u_port_b (
        .core_clk(core_clk),
        .reset(reset),
        .wr_data(wr_fire && target == usbd_pkg::TGT_PORT_B_DATA),
        .wr_dir(wr_fire && target == usbd_pkg::TGT_PORT_B_DIR),
        .wdata(wbyte),
        .pins_in(port_b_in),
        .pins_out(port_b_out),
        .pins_oe(port_b_oe),
        .dir_q(dir_q),
        .pins_level(pins_level)
    );

    assign pc_low = pc_reg[7:0];

    // Read mux; no entry for the pc upper byte exists
    always_comb begin
        rd_byte = `USBD_ZERO;
        unique case (target)
            usbd_pkg::TGT_NONE: rd_byte = `USBD_ZERO;
            usbd_pkg::TGT_INDIRECT: rd_byte = `USBD_ZERO;
            usbd_pkg::TGT_TIMER: rd_byte = timer_zero_count_reg;
            usbd_pkg::TGT_PC_LOW: rd_byte = pc_low;
            usbd_pkg::TGT_STATUS: rd_byte = status_value;
            usbd_pkg::TGT_POINTER: rd_byte = pointer_reg;
            usbd_pkg::TGT_PORT_B_DATA: rd_byte = pins_level;
            usbd_pkg::TGT_PORT_B_DIR: rd_byte = dir_q;
            usbd_pkg::TGT_PC_HOLD: rd_byte = {3'h0, pc_high_holding_reg};
            usbd_pkg::TGT_INT_CTRL: rd_byte = interrupt_control_value;
            usbd_pkg::TGT_OPTION: rd_byte = option_value;
            default: rd_byte = `USBD_ZERO;
        endcase
    end

    // Zero-wait slave: data captured in setup, ready in the access cycle
    always_ff @(posedge core_clk) begin
        if (reset) begin
            apb_rsp.pready <= 1'b0;
            apb_rsp.pslverr <= 1'b0;
            apb_rsp.prdata <= 32'h0000_0000;
        end else begin
            apb_rsp.pready <= setup_phase;
            apb_rsp.pslverr <= setup_phase & ~req_in_range;
            if (setup_phase) begin
                apb_rsp.prdata <= req_in_range ? {24'h00_0000, rd_byte} : 32'h0000_0000;
            end
        end
    end

    // Indirect pointer: no reset at all
    always_ff @(posedge core_clk) begin
        if (wr_fire && target == usbd_pkg::TGT_POINTER) begin
            pointer_reg <= wbyte;
        end
    end

    // Timer count storage: no reset at all
    always_ff @(posedge core_clk) begin
        if (wr_fire && target == usbd_pkg::TGT_TIMER) begin
            timer_zero_count_reg <= wbyte;
        end
    end

    // Holding register for pc bits 12:8
    always_ff @(posedge core_clk) begin
        if (reset) begin
            pc_high_holding_reg <= `USBD_PC_HOLD_RST;
        end else if (wr_fire && target == usbd_pkg::TGT_PC_HOLD) begin
            pc_high_holding_reg <= wbyte[4:0];
        end
    end

    // Program counter; a load beats a step in the same cycle
    always_ff @(posedge core_clk) begin
        if (reset) begin
            pc_reg <= `USBD_PC_RST;
            pc_value <= `USBD_PC_RST;
        end else if (wr_fire && target == usbd_pkg::TGT_PC_LOW) begin
            pc_reg <= {pc_high_holding_reg, wbyte};
            pc_value <= {pc_high_holding_reg, wbyte};
        end else if (pc_step) begin
            pc_reg <= pc_reg + `USBD_PC_STEP;
            pc_value <= pc_reg + `USBD_PC_STEP;
        end
    end

    // Status; low flags keep their value through every reset
    always_ff @(posedge core_clk) begin
        if (reset) begin
            if (reset_power_up) begin
                {status_value.irp, status_value.rp, status_value.to_n, status_value.pd_n}
                    <= `USBD_STATUS_POR_TOP;
            end else begin
                {status_value.irp, status_value.rp} <= `USBD_STATUS_OTHER_TOP;
                status_value.to_n <= reset_to_value;
                status_value.pd_n <= reset_pd_value;
            end
        end else begin
            if (wr_fire && target == usbd_pkg::TGT_STATUS) begin
                status_value.irp <= wbyte[7];
                status_value.rp <= wbyte[6:5];
            end
            // Core flag update wins over a bus write to the same bits
            if (alu_flags_we) begin
                {status_value.z, status_value.dc, status_value.c} <= alu_flags;
            end else if (wr_fire && target == usbd_pkg::TGT_STATUS) begin
                {status_value.z, status_value.dc, status_value.c} <= wbyte[2:0];
            end
        end
    end

    // Interrupt control; bit 0 is undefined at power-on and kept otherwise
    always_ff @(posedge core_clk) begin
        if (reset) begin
            interrupt_control_value[7:1] <= `USBD_INT_CTRL_RST_TOP;
        end else if (wr_fire && target == usbd_pkg::TGT_INT_CTRL) begin
            interrupt_control_value <= wbyte;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            option_value <= `USBD_OPTION_RST;
        end else if (wr_fire && target == usbd_pkg::TGT_OPTION) begin
            option_value <= wbyte;
        end
    end

    // Writes to unmapped or pointer-to-self targets simply match no store above

endmodule // usbd_top

`default_nettype wire

// *** hdl/usbd_regs.svh ***
// Operation
// - Unimplemented upper-bank locations read as zero and ignore writes.
// - The pc high holding register keeps pc bits 12:8 and feeds the pc upper byte on a pc load.
// - No location reads or writes the pc upper byte directly; only the low byte is mapped.
// - Common registers decode at the same offset in every bank and reach one physical register.
// - Writing port B data updates the output latch, reading it returns the sampled pin levels.
// - Status loads 0001 1xxx on power-on or brown-out reset and 000q quuu on other resets.
// - Registers with undefined reset come up undefined and keep their value on other resets.
// - Port D and port E locations have no register on the reduced-pin variant and read zero.
`ifndef USBD_REGS_SVH
`define USBD_REGS_SVH

// Register indices; byte address on the bus is four times the index
`define USBD_IDX_INDIRECT_B2 9'h100
`define USBD_IDX_TIMER_B2 9'h101
`define USBD_IDX_PC_LOW_B2 9'h102
`define USBD_IDX_STATUS_B2 9'h103
`define USBD_IDX_POINTER_B2 9'h104
`define USBD_IDX_PORT_B_B2 9'h106
`define USBD_IDX_PORT_D_B0 9'h008
`define USBD_IDX_PORT_E_B0 9'h009
`define USBD_IDX_PC_HOLD_B2 9'h10a
`define USBD_IDX_INT_CTRL_B2 9'h10b
`define USBD_IDX_INDIRECT_B3 9'h180
`define USBD_IDX_OPTION_B3 9'h181
`define USBD_IDX_PC_LOW_B3 9'h182
`define USBD_IDX_STATUS_B3 9'h183
`define USBD_IDX_POINTER_B3 9'h184
`define USBD_IDX_PORT_B_DIR_B3 9'h186
`define USBD_IDX_PC_HOLD_B3 9'h18a
`define USBD_IDX_INT_CTRL_B3 9'h18b
`define USBD_LOW_MASK 9'h07f

// Bus address layout
`define USBD_APB_IDX_MSB 10
`define USBD_APB_IDX_LSB 2
`define USBD_APB_TOP 11

// Reset values
`define USBD_STATUS_POR_TOP 5'h03
`define USBD_STATUS_OTHER_TOP 3'h0
`define USBD_PC_LOW_RST 8'h00
`define USBD_PC_HOLD_RST 5'h00
`define USBD_INT_CTRL_RST_TOP 7'h00
`define USBD_OPTION_RST 8'hff
`define USBD_PORT_B_DIR_RST 8'hff
`define USBD_OE_RST 8'h00
`define USBD_ZERO 8'h00
`define USBD_PC_RST 13'h0000
`define USBD_PC_STEP 13'h0001

`endif

// *** hdl/usbd_pkg.sv ***
`default_nettype none
`include "usbd_regs.svh"

package usbd_pkg;

    typedef enum logic [3:0] {
        TGT_NONE, TGT_INDIRECT, TGT_TIMER, TGT_PC_LOW, TGT_STATUS, TGT_POINTER,
        TGT_PORT_B_DATA, TGT_PORT_B_DIR, TGT_PC_HOLD, TGT_INT_CTRL, TGT_OPTION
    } usbd_target_t;

    typedef struct packed {
        logic irp;
        logic [1:0] rp;
        logic to_n;
        logic pd_n;
        logic z;
        logic dc;
        logic c;
    } usbd_status_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } usbd_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } usbd_apb_rsp_t;

    function automatic logic usbd_low_is(input logic [8:0] addr, input logic [8:0] idx);
        return ((addr & `USBD_LOW_MASK) == (idx & `USBD_LOW_MASK));
    endfunction

    // Bank bit 7 of the address splits the bank-pair registers
    function automatic usbd_target_t usbd_classify(input logic [8:0] addr);
        usbd_target_t t;
        t = TGT_NONE;
        // Common registers ignore the bank bits
        if (usbd_low_is(addr, `USBD_IDX_INDIRECT_B2)) t = TGT_INDIRECT;
        else if (usbd_low_is(addr, `USBD_IDX_PC_LOW_B2)) t = TGT_PC_LOW;
        else if (usbd_low_is(addr, `USBD_IDX_STATUS_B2)) t = TGT_STATUS;
        else if (usbd_low_is(addr, `USBD_IDX_POINTER_B2)) t = TGT_POINTER;
        else if (usbd_low_is(addr, `USBD_IDX_PC_HOLD_B2)) t = TGT_PC_HOLD;
        else if (usbd_low_is(addr, `USBD_IDX_INT_CTRL_B2)) t = TGT_INT_CTRL;
        else if (usbd_low_is(addr, `USBD_IDX_TIMER_B2)) t = addr[7] ? TGT_OPTION : TGT_TIMER;
        else if (usbd_low_is(addr, `USBD_IDX_PORT_B_B2)) begin
            t = addr[7] ? TGT_PORT_B_DIR : TGT_PORT_B_DATA;
        end
        // Port D/E and every other location fall to none
        return t;
    endfunction

endpackage : usbd_pkg

`default_nettype wire

// *** hdl/usbd_decode.sv ***
`default_nettype none

module usbd_decode (
    // Requested address
    input wire logic [8:0] addr,
    // Indirect pointer context
    input wire logic irp,
    input wire logic [7:0] pointer,
    // Resolved target
    output usbd_pkg::usbd_target_t target,
    output logic [8:0] eff_addr
);

    usbd_pkg::usbd_target_t direct_t;
    usbd_pkg::usbd_target_t via_t;
    logic [8:0] via_addr;

    assign via_addr = {irp, pointer};
    assign direct_t = usbd_pkg::usbd_classify(addr);
    assign via_t = usbd_pkg::usbd_classify(via_addr);

    // Pointer back to the indirect location itself resolves to nothing
    always_comb begin
        target = direct_t;
        eff_addr = addr;
        if (direct_t == usbd_pkg::TGT_INDIRECT) begin
            eff_addr = via_addr;
            target = (via_t == usbd_pkg::TGT_INDIRECT) ? usbd_pkg::TGT_NONE : via_t;
        end
    end

endmodule // usbd_decode

`default_nettype wire

// *** hdl/usbd_port_b.sv ***
`default_nettype none
`include "usbd_regs.svh"

module usbd_port_b (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Register writes
    input wire logic wr_data,
    input wire logic wr_dir,
    input wire logic [7:0] wdata,
    // Pins
    input wire logic [7:0] pins_in,
    output logic [7:0] pins_out,
    output logic [7:0] pins_oe,
    // Read back
    output logic [7:0] dir_q,
    output logic [7:0] pins_level
);

    logic [7:0] latch_reg;

    // Latch has no reset: undefined at power-on, kept on other resets
    always_ff @(posedge core_clk) begin
        if (wr_data) begin
            latch_reg <= wdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            dir_q <= `USBD_PORT_B_DIR_RST;
            pins_oe <= `USBD_OE_RST;
        end else if (wr_dir) begin
            dir_q <= wdata;
            pins_oe <= ~wdata;
        end
    end

    // Output stage follows the latch one flop later
    always_ff @(posedge core_clk) begin
        pins_out <= latch_reg;
    end

    // Reads see the pins, not the latch
    assign pins_level = pins_in;

endmodule // usbd_port_b

`default_nettype wire

// *** verif/usbd_top_chk.sv ***
`default_nettype none
module usbd_top_chk (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    input wire logic reset_power_up,
    input wire logic reset_to_value,
    input wire logic reset_pd_value,
    // Bus
    input wire usbd_pkg::usbd_apb_req_t apb_req,
    input wire usbd_pkg::usbd_apb_rsp_t apb_rsp,
    // Core and pins
    input wire logic pc_step,
    input wire logic [7:0] port_b_in,
    input wire logic [7:0] port_b_out,
    input wire logic [12:0] pc_value,
    input wire usbd_pkg::usbd_status_t status_value,
    input wire logic [7:0] interrupt_control_value
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    logic [4:0] hold_reg;
    wire setup = apb_req.psel && !apb_req.penable && !apb_req.paddr[11];
    wire rd_setup = setup && !apb_req.pwrite;
    wire wacc = apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite
        && !apb_req.paddr[11];
    wire [6:0] low = apb_req.paddr[8:2];
    // Direct writes only; indirect ones are not tracked
    always_ff @(posedge core_clk) begin
        if (reset) begin
            hold_reg <= 5'h00;
        end else if (wacc && low == 7'h0a) begin
            hold_reg <= apb_req.pwdata[4:0];
        end
    end
    ready_one_a: assert property (setup |=> apb_rsp.pready ##1 !apb_rsp.pready)
        else $error("pready not one cycle");
    hole_zero_a: assert property (
        rd_setup && (low >= 7'h0c || low inside {7'h05, 7'h07, 7'h08, 7'h09})
        |=> apb_rsp.prdata == 32'h0) else $error("hole read not zero");
    bus_err_a: assert property (apb_req.psel && !apb_req.penable && apb_req.paddr[11]
        |=> apb_rsp.pslverr && apb_rsp.prdata == 32'h0) else $error("bad range answer");
    pc_load_a: assert property (
        wacc && low == 7'h02 |=> pc_value == {$past(hold_reg), $past(apb_req.pwdata[7:0])})
        else $error("pc load wrong");
    pc_upper_a: assert property (
        wacc && low == 7'h0a && !pc_step |=> pc_value == $past(pc_value))
        else $error("pc upper written");
    latch_out_a: assert property (
        wacc && low == 7'h06 && !apb_req.paddr[9]
        |-> ##2 port_b_out == $past(apb_req.pwdata[7:0], 2)) else $error("latch wrong");
    pin_read_a: assert property (
        rd_setup && low == 7'h06 && !apb_req.paddr[9] && $stable(port_b_in)
        && port_b_in == $past(port_b_in, 2) |=> apb_rsp.prdata == {24'h0, $past(port_b_in)})
        else $error("pin read wrong");
    por_status_a: assert property (
        disable iff (1'b0) reset && reset_power_up |=> status_value[7:3] == 5'h03)
        else $error("power-up status wrong");
    warm_status_a: assert property (
        disable iff (1'b0) reset && !reset_power_up |=> status_value[7:3] ==
        {3'h0, $past(reset_to_value), $past(reset_pd_value)}) else $error("warm status wrong");
    warm_keep_a: assert property (
        disable iff (1'b0) reset && !reset_power_up |=> status_value[2:0] ==
        $past(status_value[2:0])
        && interrupt_control_value[0] == $past(interrupt_control_value[0]))
        else $error("warm reset lost value");
endmodule // usbd_top_chk

bind usbd_top usbd_top_chk u_usbd_top_chk (.core_clk(core_clk), .reset(reset),
    .reset_power_up(reset_power_up), .reset_to_value(reset_to_value),
    .reset_pd_value(reset_pd_value), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .pc_step(pc_step), .port_b_in(port_b_in), .port_b_out(port_b_out),
    .pc_value(pc_value), .status_value(status_value),
    .interrupt_control_value(interrupt_control_value));
`default_nettype wire

// *** verif/usbd_top_test.sv ***
`default_nettype none
module usbd_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, reset, reset_power_up, reset_to_value, reset_pd_value, pc_step;
    logic alu_flags_we;
    logic [2:0] alu_flags;
    logic [7:0] port_b_in, port_b_out, port_b_oe, option_value, interrupt_control_value, d, p;
    logic [12:0] pc_value;
    usbd_pkg::usbd_apb_req_t apb_req;
    usbd_pkg::usbd_apb_rsp_t apb_rsp;
    usbd_pkg::usbd_status_t status_value;
    logic [31:0] exp_q[$];
    logic [31:0] exp_v;
    logic [9:0] holes[10] = '{10'h105, 10'h107, 10'h108, 10'h109, 10'h10c, 10'h10f,
        10'h185, 10'h188, 10'h18f, 10'h008};
    int fail_count, comparisons, cycles;
    usbd_top u_usbd_top (.core_clk(core_clk), .reset(reset), .reset_power_up(reset_power_up),
        .reset_to_value(reset_to_value), .reset_pd_value(reset_pd_value), .apb_req(apb_req),
        .apb_rsp(apb_rsp), .pc_step(pc_step), .alu_flags_we(alu_flags_we),
        .alu_flags(alu_flags), .port_b_in(port_b_in), .port_b_out(port_b_out),
        .port_b_oe(port_b_oe), .pc_value(pc_value), .status_value(status_value),
        .option_value(option_value), .interrupt_control_value(interrupt_control_value));
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, e, g);
        end
    endtask
    // Holds the request until pready is seen at an edge
    task automatic xfer(input logic w, input logic [9:0] a, input logic [7:0] v);
        @(posedge core_clk);
        apb_req <= '{1'b1, 1'b0, w, {a, 2'b00}, {24'h0, v}};
        @(posedge core_clk);
        apb_req.penable <= 1'b1;
        @(posedge core_clk);
        while (apb_rsp.pready !== 1'b1) @(posedge core_clk);
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask
    task automatic rd(input logic [9:0] a, input logic [7:0] e);
        exp_q.push_back({24'h0, e});
        xfer(1'b0, a, 8'h00);
    endtask
    always @(posedge core_clk) begin
        if (apb_req.psel && apb_req.penable && !apb_req.pwrite && apb_rsp.pready === 1'b1) begin
            exp_v = exp_q.pop_front();
            chk("prdata", exp_v, apb_rsp.prdata);
        end
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            close_out();
        end
    end
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    initial begin
        {reset, reset_power_up} = 2'b11;
        {reset_to_value, reset_pd_value, pc_step, alu_flags_we} = 4'h0;
        alu_flags = 3'h0;
        port_b_in = 8'h00;
        apb_req = '0;
        void'($urandom(32'h879a1249));
        repeat (16) @(posedge core_clk);
        reset <= 1'b0;
        rd(10'h181, 8'hff);
        rd(10'h186, 8'hff);
        rd(10'h10a, 8'h00);
        chk("oe", 8'h00, port_b_oe);
        @(posedge core_clk);
        alu_flags <= 3'($urandom);
        alu_flags_we <= 1'b1;
        @(posedge core_clk);
        alu_flags_we <= 1'b0;
        rd(10'h183, {5'h03, alu_flags});
        d = 8'($urandom);
        xfer(1'b1, 10'h104, d);
        for (int i = 0; i < 4; i++) rd({1'b0, 2'(i), 7'h04}, d);
        $display("reset and mirror test done");
        xfer(1'b1, 10'h184, 8'h0a);
        d = 8'($urandom);
        xfer(1'b1, 10'h100, d);
        rd(10'h18a, {3'h0, d[4:0]});
        rd(10'h180, {3'h0, d[4:0]});
        d = 8'($urandom);
        p = 8'($urandom);
        xfer(1'b1, 10'h10a, d);
        xfer(1'b1, 10'h182, p);
        @(posedge core_clk);
        chk("pc", {d[4:0], p}, pc_value);
        pc_step <= 1'b1;
        @(posedge core_clk);
        pc_step <= 1'b0;
        @(posedge core_clk);
        chk("pc step", {d[4:0], p} + 13'h0001, pc_value);
        rd(10'h102, p + 8'h01);
        foreach (holes[i]) begin
            // Hole writes never reach the irq enable or flag locations
            xfer(1'b1, holes[i], 8'($urandom));
            rd(holes[i], 8'h00);
        end
        rd(10'h303, 8'h00);
        $display("indirect, pc and hole test done");
        d = 8'($urandom);
        port_b_in <= 8'($urandom);
        xfer(1'b1, 10'h106, d);
        rd(10'h106, port_b_in);
        chk("pins out", d, port_b_out);
        xfer(1'b1, 10'h186, 8'h00);
        rd(10'h186, 8'h00);
        chk("oe", 8'hff, port_b_oe);
        d = 8'($urandom);
        xfer(1'b1, 10'h18b, d);
        rd(10'h10b, d);
        @(posedge core_clk);
        {reset, reset_power_up, reset_to_value, reset_pd_value} <= 4'b1001;
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        rd(10'h103, {5'h01, alu_flags});
        rd(10'h104, 8'h0a);
        rd(10'h10b, {7'h0, d[0]});
        rd(10'h181, 8'hff);
        $display("port and warm reset test done");
        close_out();
    end
endmodule // usbd_top_test
`default_nettype wire
